// ### logic/pstab_map.vh
// constants for the program space table access block
`ifndef PSTAB_MAP_VH
`define PSTAB_MAP_VH

// ****************************************************************
// register bus offsets
// ****************************************************************
`define PSTAB_OFF_TBLPG      4'h0
`define PSTAB_OFF_RDPG       4'h1
`define PSTAB_OFF_WRPG       4'h2
`define PSTAB_OFF_LSTART_L   4'h3
`define PSTAB_OFF_LSTART_H   4'h4
`define PSTAB_OFF_STATUS     4'h5
`define PSTAB_OFF_LSTART_LD  4'h6

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define PSTAB_TBLPG_RST      8'h00
`define PSTAB_RDPG_RST       10'h001
`define PSTAB_WRPG_RST       9'h001
`define PSTAB_RDPG_PS_MIN    10'h200
`define PSTAB_TBLPG_CFG_BIT  7
`define PSTAB_PAGE_SEL_BIT   15
`define PSTAB_ZERO16         16'h0000
`define PSTAB_ZERO8          8'h00
`define PSTAB_PC_STEP        23'h000002

// ****************************************************************
// operation codes
// ****************************************************************
`define PSTAB_OP_NONE        3'h0
`define PSTAB_OP_RD_LOW      3'h1
`define PSTAB_OP_RD_HIGH     3'h2
`define PSTAB_OP_WT_LOW      3'h3
`define PSTAB_OP_WT_HIGH     3'h4
`define PSTAB_OP_PG_RD       3'h5
`define PSTAB_OP_PG_WT       3'h6

`endif

// ### logic/pstab_read_fmt.v
// table read result formatting for low and high operations
`timescale 1ns/100ps
`include "pstab_map.vh"

module pstab_read_fmt (
   // operation
   input  wire        high_i,
   input  wire        byte_mode_i,
   input  wire        byte_sel_i,
   // program word
   input  wire [23:0] prog_word_i,
   // result
   output reg  [15:0] data_o
);

   always @* begin
      data_o = `PSTAB_ZERO16;
      if (!high_i) begin
         if (!byte_mode_i)
            data_o = prog_word_i[15:0];
         else if (byte_sel_i)
            data_o = {`PSTAB_ZERO8, prog_word_i[15:8]};
         else
            data_o = {`PSTAB_ZERO8, prog_word_i[7:0]};
      end else begin
         if (!byte_mode_i)
            data_o = {`PSTAB_ZERO8, prog_word_i[23:16]};
         else if (!byte_sel_i)
            data_o = {`PSTAB_ZERO8, prog_word_i[23:16]};
         else
            data_o = `PSTAB_ZERO16;
      end
   end

endmodule

// ### logic/pstab_page_map.v
// paged data address translation for read and write pages
`timescale 1ns/100ps
`include "pstab_map.vh"

module pstab_page_map (
   // request
   input  wire        write_i,
   input  wire [15:0] addr_i,
   // pages
   input  wire [9:0]  read_page_i,
   input  wire [8:0]  write_page_i,
   // result
   output reg         paged_o,
   output reg         to_prog_o,
   output reg  [23:0] ext_addr_o
);

   always @* begin
      paged_o    = addr_i[`PSTAB_PAGE_SEL_BIT];
      to_prog_o  = 1'b0;
      ext_addr_o = {8'h00, addr_i};
      if (addr_i[`PSTAB_PAGE_SEL_BIT]) begin
         if (write_i) begin
            // write page only ever lands in data space
            ext_addr_o = {write_page_i[8:0], addr_i[14:0]};
         end else if (read_page_i >= `PSTAB_RDPG_PS_MIN) begin
            to_prog_o  = 1'b1;
            // 8 Mbyte view: page bits 7..0 over program words, bit 8 dropped in pstab_top
            ext_addr_o = {read_page_i[8:0], addr_i[14:0]};
         end else begin
            ext_addr_o = {read_page_i[8:0], addr_i[14:0]};
         end
      end
   end

endmodule

// ### logic/pstab_top.v
// program space table access and paged data space address mapping
//
// Functional notes
// - read page at or above 200h reads program
// - paged writes never reach program space
// - reads use read page, writes write page
// - page plus upper address picks 32K window
// - program counter steps by two per word
// - low ops lower word, high ops upper byte
// - table ops reach program space directly
// - table reads have byte and word modes
// - word low read returns bits 15..0
// - byte low read picks byte by select
// - word high read zero-extends bits 23..16
// - byte high read phantom byte reads zero
// - table page register, bit 7 selects config
// - loop start registers are read-only
`timescale 1ns/100ps
`include "pstab_map.vh"

module pstab_top (
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        reset_i,
   // register port
   input  wire [3:0]  reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [15:0] reg_rdata_o,
   // core operation request
   input  wire        op_valid_i,
   input  wire [2:0]  op_code_i,
   input  wire        op_byte_i,
   input  wire [15:0] op_addr_i,
   input  wire [15:0] op_wdata_i,
   // loop start capture from core sequencer
   input  wire        loop_load_i,
   input  wire [22:0] loop_pc_i,
   // program counter step
   input  wire        pc_advance_i,
   input  wire        pc_load_i,
   input  wire [22:0] pc_load_val_i,
   output reg  [22:0] pc_o,
   // program memory port
   output reg         prog_en_o,
   output reg         prog_we_o,
   output reg         prog_we_high_o,
   output reg         prog_cfg_o,
   output reg  [23:0] prog_addr_o,
   output reg  [23:0] prog_wdata_o,
   input  wire [23:0] prog_rdata_i,
   // data memory port
   output reg         data_en_o,
   output reg         data_we_o,
   output reg  [23:0] data_addr_o,
   output reg  [15:0] data_wdata_o,
   input  wire [15:0] data_rdata_i,
   // operation result
   output reg         rd_valid_o,
   output reg  [15:0] rd_data_o
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam ST_IDLE = 2'b00;
   localparam ST_PROG = 2'b01;
   localparam ST_DATA = 2'b10;

   // ****************************************************************
   // registers
   // ****************************************************************
   reg  [7:0]  table_page_reg;
   reg  [9:0]  data_read_page_reg;
   reg  [8:0]  data_write_page_reg;
   reg  [7:0]  loop_start_addr_high;
   reg  [15:0] loop_start_addr_low;
   reg  [1:0]  state;
   reg         pend_high;
   reg         pend_byte;
   reg         pend_sel;
   reg         last_to_prog;

   wire [15:0] fmt_data;
   wire        pg_paged;
   wire        pg_to_prog;
   wire [23:0] pg_addr;

   reg  [15:0] next_rdata;

   function is_table_op;
      input [2:0] code;
      begin
         is_table_op = (code == `PSTAB_OP_RD_LOW) ||
                       (code == `PSTAB_OP_RD_HIGH) ||
                       (code == `PSTAB_OP_WT_LOW) ||
                       (code == `PSTAB_OP_WT_HIGH);
      end
   endfunction

   function [23:0] table_addr;
      input [7:0]  page;
      input [15:0] addr;
      begin
         // word address; byte select bit dropped
         table_addr = {page, addr[15:1], 1'b0};
      end
   endfunction

   // ****************************************************************
   // helpers
   // ****************************************************************
   pstab_read_fmt u_fmt (
      .high_i      (pend_high),
      .byte_mode_i (pend_byte),
      .byte_sel_i  (pend_sel),
      .prog_word_i (prog_rdata_i),
      .data_o      (fmt_data)
   );

   pstab_page_map u_map (
      .write_i      (op_code_i == `PSTAB_OP_PG_WT),
      .addr_i       (op_addr_i),
      .read_page_i  (data_read_page_reg),
      .write_page_i (data_write_page_reg),
      .paged_o      (pg_paged),
      .to_prog_o    (pg_to_prog),
      .ext_addr_o   (pg_addr)
   );

   // ****************************************************************
   // register port
   // ****************************************************************
   always @* begin
      next_rdata = `PSTAB_ZERO16;
      case (reg_addr_i)
         `PSTAB_OFF_TBLPG:    next_rdata = {8'h00, table_page_reg};
         `PSTAB_OFF_RDPG:     next_rdata = {6'h00, data_read_page_reg};
         `PSTAB_OFF_WRPG:     next_rdata = {7'h00, data_write_page_reg};
         `PSTAB_OFF_LSTART_L: next_rdata = loop_start_addr_low;
         `PSTAB_OFF_LSTART_H: next_rdata = {8'h00, loop_start_addr_high};
         `PSTAB_OFF_STATUS:   next_rdata = {13'h0000, last_to_prog, state};
         default:             next_rdata = `PSTAB_ZERO16;
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         reg_rdata_o         <= `PSTAB_ZERO16;
         table_page_reg      <= `PSTAB_TBLPG_RST;
         data_read_page_reg  <= `PSTAB_RDPG_RST;
         data_write_page_reg <= `PSTAB_WRPG_RST;
         loop_start_addr_high <= `PSTAB_ZERO8;
         loop_start_addr_low <= `PSTAB_ZERO16;
      end else begin
         reg_rdata_o <= reg_rd_i ? next_rdata : `PSTAB_ZERO16;
         if (reg_wr_i) begin
            case (reg_addr_i)
               `PSTAB_OFF_TBLPG:
                  table_page_reg <= reg_wdata_i[7:0];
               `PSTAB_OFF_RDPG:
                  data_read_page_reg <= reg_wdata_i[9:0];
               `PSTAB_OFF_WRPG:
                  data_write_page_reg <= reg_wdata_i[8:0];
               // loop start writes fall here and are dropped
               default: ;
            endcase
         end
         // only the core sequencer updates loop start
         if (loop_load_i) begin
            loop_start_addr_high <= {1'b0, loop_pc_i[22:16]};
            loop_start_addr_low  <= loop_pc_i[15:0];
         end
      end
   end

   // ****************************************************************
   // program counter
   // ****************************************************************
   always @(posedge ref_clk_i) begin
      if (reset_i)
         pc_o <= 23'h000000;
      else if (pc_load_i)
         pc_o <= {pc_load_val_i[22:1], 1'b0};
      else if (pc_advance_i)
         pc_o <= pc_o + `PSTAB_PC_STEP;
   end

   // ****************************************************************
   // operation sequencing
   // ****************************************************************
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         state          <= ST_IDLE;
         prog_en_o      <= 1'b0;
         prog_we_o      <= 1'b0;
         prog_we_high_o <= 1'b0;
         prog_cfg_o     <= 1'b0;
         prog_addr_o    <= 24'h000000;
         prog_wdata_o   <= 24'h000000;
         data_en_o      <= 1'b0;
         data_we_o      <= 1'b0;
         data_addr_o    <= 24'h000000;
         data_wdata_o   <= `PSTAB_ZERO16;
         rd_valid_o     <= 1'b0;
         rd_data_o      <= `PSTAB_ZERO16;
         pend_high      <= 1'b0;
         pend_byte      <= 1'b0;
         pend_sel       <= 1'b0;
         last_to_prog   <= 1'b0;
      end else begin
         prog_en_o      <= 1'b0;
         prog_we_o      <= 1'b0;
         prog_we_high_o <= 1'b0;
         data_en_o      <= 1'b0;
         data_we_o      <= 1'b0;
         rd_valid_o     <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (op_valid_i && is_table_op(op_code_i)) begin
                  // straight to program memory, no data path
                  prog_en_o   <= 1'b1;
                  prog_addr_o <= table_addr(table_page_reg, op_addr_i);
                  prog_cfg_o  <=
                     table_page_reg[`PSTAB_TBLPG_CFG_BIT];
                  pend_high <= (op_code_i == `PSTAB_OP_RD_HIGH);
                  pend_byte <= op_byte_i;
                  pend_sel  <= op_addr_i[0];
                  if (op_code_i == `PSTAB_OP_WT_LOW) begin
                     prog_we_o    <= 1'b1;
                     prog_wdata_o <= {8'h00, op_wdata_i};
                  end else if (op_code_i == `PSTAB_OP_WT_HIGH) begin
                     prog_we_high_o <= 1'b1;
                     prog_wdata_o   <= {op_wdata_i[7:0], 16'h0000};
                  end else begin
                     state <= ST_PROG;
                  end
               end else if (op_valid_i &&
                            op_code_i == `PSTAB_OP_PG_RD) begin
                  pend_high <= 1'b0;
                  pend_byte <= 1'b0;
                  pend_sel  <= 1'b0;
                  last_to_prog <= pg_to_prog;
                  if (pg_to_prog) begin
                     prog_en_o   <= 1'b1;
                     prog_cfg_o  <= 1'b0;
                     prog_addr_o <= {pg_addr[22:0], 1'b0};
                     state       <= ST_PROG;
                  end else begin
                     data_en_o   <= 1'b1;
                     data_addr_o <= pg_addr;
                     state       <= ST_DATA;
                  end
               end else if (op_valid_i &&
                            op_code_i == `PSTAB_OP_PG_WT) begin
                  last_to_prog <= 1'b0;
                  data_en_o    <= 1'b1;
                  data_we_o    <= 1'b1;
                  data_addr_o  <= pg_addr;
                  data_wdata_o <= op_wdata_i;
               end
            end
            ST_PROG: begin
               rd_valid_o <= 1'b1;
               rd_data_o  <= fmt_data;
               state      <= ST_IDLE;
            end
            ST_DATA: begin
               rd_valid_o <= 1'b1;
               rd_data_o  <= data_rdata_i;
               state      <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule

// ### tb/pstab_tb_pat.svh
// memory contents shared by the memory model and the bench
function automatic [23:0] pat_prog(input [23:0] a);
   pat_prog = {a[7:0], a[15:0]} ^ 24'hA5C33C;
endfunction
function automatic [15:0] pat_data(input [23:0] a);
   pat_data = a[15:0] ^ 16'h6E91;
endfunction

// ### tb/pstab_checker.sv
// assertion checker for the table access block
`timescale 1ns/100ps
module pstab_checker (
   // clock and reset
   input wire        ref_clk_i,
   input wire        reset_i,
   // register writes
   input wire [3:0]  reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire        reg_wr_i,
   // operation and counter
   input wire        op_valid_i,
   input wire [2:0]  op_code_i,
   input wire        op_byte_i,
   input wire [15:0] op_addr_i,
   input wire        pc_advance_i,
   input wire        pc_load_i,
   input wire [22:0] pc_o,
   // memory side and result
   input wire        prog_en_o,
   input wire        prog_we_o,
   input wire        prog_we_high_o,
   input wire        prog_cfg_o,
   input wire [23:0] prog_addr_o,
   input wire        data_en_o,
   input wire        data_we_o,
   input wire [23:0] data_addr_o,
   input wire        rd_valid_o,
   input wire [15:0] rd_data_o
);
   // page shadows, so expectations never lean on the design
   reg [7:0] tp;
   reg [9:0] rp;
   reg [8:0] wp;
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         tp <= 8'h00;
         rp <= 10'h001;
         wp <= 9'h001;
      end else if (reg_wr_i) begin
         if (reg_addr_i == 4'h0) tp <= reg_wdata_i[7:0];
         if (reg_addr_i == 4'h1) rp <= reg_wdata_i[9:0];
         if (reg_addr_i == 4'h2) wp <= reg_wdata_i[8:0];
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_pc_step: assert property (pc_advance_i && !pc_load_i |=>
      pc_o == $past(pc_o) + 23'h000002) else $error("pc step wrong");
   a_write_table_only: assert property (prog_we_o || prog_we_high_o |->
      $past(op_valid_i) && ($past(op_code_i) == 3'h3 ||
      $past(op_code_i) == 3'h4)) else $error("stray program write");
   a_table_address: assert property ($past(op_valid_i) &&
      $past(op_code_i) != 3'h0 && $past(op_code_i) < 3'h5 |-> prog_en_o &&
      prog_cfg_o == tp[7] && prog_addr_o == {tp, $past(op_addr_i[15:1]),
      1'b0}) else $error("table address wrong");
   a_read_latency: assert property ((prog_en_o || data_en_o) &&
      !prog_we_o && !prog_we_high_o && !data_we_o |=> rd_valid_o)
      else $error("read result missing");
   a_high_word: assert property (rd_valid_o && $past(op_code_i, 2) == 3'h2
      && !$past(op_byte_i, 2) |-> rd_data_o[15:8] == 8'h00)
      else $error("high word not zero extended");
   a_high_phantom: assert property (rd_valid_o && $past(op_byte_i, 2) &&
      $past(op_code_i, 2) == 3'h2 && $past(op_addr_i[0], 2) |->
      rd_data_o == 16'h0000) else $error("phantom byte not zero");
   a_paged_prog_read: assert property ($past(op_valid_i) &&
      $past(op_code_i) == 3'h5 && $past(op_addr_i[15]) |->
      prog_en_o == (rp >= 10'h200) && data_en_o == (rp < 10'h200))
      else $error("paged read went to wrong space");
   a_paged_write: assert property ($past(op_valid_i) &&
      $past(op_code_i) == 3'h6 |-> data_we_o && !prog_en_o &&
      data_addr_o == ($past(op_addr_i[15]) ? {wp, $past(op_addr_i[14:0])}
      : {8'h00, $past(op_addr_i)})) else $error("paged write wrong");
endmodule
bind pstab_top pstab_checker chk (.*);

// ### tb/pstab_mem_model.sv
// program and data memory standing behind the table access block
`timescale 1ns/100ps
module pstab_mem_model (
   // clock
   input  wire        ref_clk_i,
   // program memory
   input  wire        prog_en_i,
   input  wire [23:0] prog_addr_i,
   output wire [23:0] prog_rdata_o,
   // data memory
   input  wire        data_en_i,
   input  wire [23:0] data_addr_i,
   output wire [15:0] data_rdata_o
);
`include "pstab_tb_pat.svh"
   reg        p_hold = 1'b0;
   reg        d_hold = 1'b0;
   reg [23:0] p_last = 24'h000000;
   reg [15:0] d_last = 16'h0000;
   // word holds one cycle past the enable, then reads inverted
   always @(posedge ref_clk_i) begin
      p_hold <= prog_en_i;
      d_hold <= data_en_i;
      p_last <= prog_en_i ? pat_prog(prog_addr_i) : p_last;
      d_last <= data_en_i ? pat_data(data_addr_i) : d_last;
   end
   assign prog_rdata_o = prog_en_i ? pat_prog(prog_addr_i) :
                         p_hold ? p_last : ~p_last;
   assign data_rdata_o = data_en_i ? pat_data(data_addr_i) :
                         d_hold ? d_last : ~d_last;
endmodule

// ### tb/tb_top.sv
// self-checking bench for the table access block
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: %h versus %h", $time, g, e); end end
module tb_top;
`include "pstab_tb_pat.svh"
   logic        ref_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0, op_valid_i = 1'b0, op_byte_i = 1'b0;
   logic        loop_load_i = 1'b0, pc_advance_i = 1'b0, pc_load_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [2:0]  op_code_i = 3'h0;
   logic [15:0] reg_wdata_i = 16'h0000, op_addr_i = 16'h0000;
   logic [15:0] op_wdata_i = 16'h0000;
   logic [22:0] loop_pc_i = 23'h000000, pc_load_val_i = 23'h000000;
   wire  [15:0] reg_rdata_o, rd_data_o, data_wdata_o, data_rdata_i;
   wire  [22:0] pc_o;
   wire  [23:0] prog_addr_o, prog_wdata_o, prog_rdata_i, data_addr_o;
   wire         prog_en_o, prog_we_o, prog_we_high_o, prog_cfg_o;
   wire         data_en_o, data_we_o, rd_valid_o;
   int          n_errors = 0, n_compared = 0, cycles = 0;
   pstab_top dut (.*);
   pstab_mem_model mem (.ref_clk_i(ref_clk_i), .prog_en_i(prog_en_o),
      .prog_addr_i(prog_addr_o), .prog_rdata_o(prog_rdata_i),
      .data_en_i(data_en_o), .data_addr_i(data_addr_o),
      .data_rdata_o(data_rdata_i));
   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic print_verdict;
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input [3:0] a, input [15:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input [3:0] a, input [15:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(reg_rdata_o, e)
   endtask
   // returns one nanosecond into the cycle of the memory strobes
   task automatic op(input [2:0] c, input b, input [15:0] a, w);
      @(posedge ref_clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= c;
      op_byte_i <= b;
      op_addr_i <= a;
      op_wdata_i <= w;
      @(posedge ref_clk_i);
      op_valid_i <= 1'b0;
      #1;
   endtask
   task automatic res(input [15:0] e, input [15:0] m);
      @(posedge ref_clk_i);
      #1;
      `CHK({rd_valid_o, rd_data_o & m}, {1'b1, e & m})
   endtask
   function automatic [15:0] fmt(input [2:0] c, input b, s, input [23:0] p);
      if (c == 3'h1) begin
         fmt = !b ? p[15:0] : {8'h00, s ? p[15:8] : p[7:0]};
      end else begin
         fmt = (b && s) ? 16'h0000 : {8'h00, p[23:16]};
      end
   endfunction
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rd_chk(4'h0, 16'h0000);
      rd_chk(4'h1, 16'h0001);
      rd_chk(4'h2, 16'h0001);
      rd_chk(4'hF, 16'h0000);
      rd_chk(4'h5, 16'h0000);
      `CHK(pc_o, 23'h000000)
   endtask
   task automatic t_loop;
      @(posedge ref_clk_i);
      loop_load_i <= 1'b1;
      loop_pc_i <= 23'h3ABCDE;
      @(posedge ref_clk_i);
      loop_load_i <= 1'b0;
      wr(4'h3, 16'h0000);
      wr(4'h4, 16'h0000);
      rd_chk(4'h3, 16'hBCDE);
      rd_chk(4'h4, 16'h003A);
   endtask
   task automatic t_pc;
      @(posedge ref_clk_i);
      pc_advance_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      pc_advance_i <= 1'b0;
      pc_load_i <= 1'b1;
      pc_load_val_i <= 23'h001235;
      #1;
      `CHK(pc_o, 23'h000006)
      @(posedge ref_clk_i);
      pc_load_i <= 1'b0;
      #1;
      `CHK(pc_o, 23'h001234)
   endtask
   task automatic t_table;
      logic [7:0]  pg;
      logic [2:0]  c;
      logic [15:0] a, m;
      logic [23:0] pa;
      for (int i = 0; i < 16; i++) begin
         pg = i[3] ? 8'h85 : 8'h12;
         c = i[2] ? 3'h2 : 3'h1;
         a = {15'h26B5, i[0]};
         pa = {pg, a[15:1], 1'b0};
         m = (c == 3'h1 && i[1]) ? 16'h00FF : 16'hFFFF;
         wr(4'h0, {8'h00, pg});
         op(c, i[1], a, 16'h0000);
         `CHK({prog_en_o, prog_we_o, prog_cfg_o}, {2'b10, pg[7]})
         `CHK(prog_addr_o, pa)
         res(fmt(c, i[1], a[0], pat_prog(pa)), m);
      end
      op(3'h3, 1'b0, 16'h2468, 16'hBEEF);
      `CHK({prog_en_o, prog_we_o, prog_we_high_o}, 3'b110)
      `CHK({prog_addr_o, prog_wdata_o[15:0]}, 40'h852468BEEF)
      op(3'h4, 1'b0, 16'h2468, 16'hBEEF);
      `CHK({prog_en_o, prog_we_o, prog_we_high_o}, 3'b101)
      `CHK({prog_addr_o, prog_wdata_o[23:16]}, 32'h852468EF)
   endtask
   task automatic t_paged;
      logic [9:0]  pg;
      logic [23:0] pa, pw;
      for (int i = 0; i < 3; i++) begin
         pg = (i == 0) ? 10'h1FF : (i == 1) ? 10'h200 : 10'h3FF;
         pa = {pg[7:0], 15'h0ACE, 1'b0};
         pw = pat_prog(pa);
         wr(4'h1, {6'h00, pg});
         op(3'h5, 1'b0, 16'h8ACE, 16'h0000);
         if (pg < 10'h200) begin
            `CHK({data_en_o, prog_en_o}, 2'b10)
            `CHK(data_addr_o, {pg[8:0], 15'h0ACE})
            res(pat_data({pg[8:0], 15'h0ACE}), 16'hFFFF);
         end else begin
            `CHK({data_en_o, prog_en_o, prog_cfg_o, prog_addr_o}, {3'b010, pa})
            res(pw[15:0], 16'hFFFF);
         end
      end
      op(3'h5, 1'b0, 16'h1234, 16'h0000);
      `CHK({prog_en_o, data_addr_o}, 25'h0001234)
      res(pat_data(24'h001234), 16'hFFFF);
      wr(4'h2, 16'h01AB);
      op(3'h6, 1'b0, 16'h8ACE, 16'h3C3C);
      `CHK({data_we_o, prog_en_o, prog_we_o, data_wdata_o}, 19'h43C3C)
      `CHK(data_addr_o, {9'h1AB, 15'h0ACE})
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict;
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_loop;
      t_pc;
      t_table;
      t_paged;
      print_verdict;
   end
endmodule
